// ==== rtl/ieb_pkg.sv ====
package ieb_pkg;

    // Register byte addresses on the AXI4-Lite bus
    localparam logic [3:0] ADDR_ENABLE_FIRST  = 4'h0;
    localparam logic [3:0] ADDR_ENABLE_SECOND = 4'h4;

    // Reset values
    localparam logic [15:0] RESET_ENABLE_FIRST  = 16'h0000;
    localparam logic [15:0] RESET_ENABLE_SECOND = 16'h0000;

    // Implemented bits of the second register; bit 5 is unimplemented
    localparam logic [15:0] MASK_ENABLE_SECOND = 16'hFFDF;

    // Field positions, first register
    localparam int POS_EXT_IRQ_ZERO     = 0;
    localparam int POS_CAPTURE_ONE      = 1;
    localparam int POS_COMPARE_ONE      = 2;

    // Field positions, second register
    localparam int POS_I2C_SLAVE_EVENT  = 0;
    localparam int POS_I2C_MASTER_EVENT = 1;
    localparam int POS_COMPARATOR       = 2;
    localparam int POS_PIN_CHANGE       = 3;
    localparam int POS_EXT_IRQ_ONE      = 4;
    localparam int POS_CAPTURE_SEVEN    = 6;
    localparam int POS_CAPTURE_EIGHT    = 7;
    localparam int POS_DMA_CHAN_TWO     = 8;
    localparam int POS_COMPARE_THREE    = 9;
    localparam int POS_COMPARE_FOUR     = 10;
    localparam int POS_TIMER_FOUR       = 11;
    localparam int POS_TIMER_FIVE       = 12;
    localparam int POS_EXT_IRQ_TWO      = 13;
    localparam int POS_SERIAL_TWO_RX    = 14;
    localparam int POS_SERIAL_TWO_TX    = 15;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Raw requests and gated requests, one bit per register position
    typedef struct packed {
        logic [15:0] first;
        logic [15:0] second;
    } ieb_req_t;

endpackage

// ==== rtl/ieb_enable_bank.sv ====
`timescale 1ns/1ns
// Overview of operation
// RQ1 - A source whose enable bit is one passes its request on to the interrupt controller.
// RQ2 - A source whose enable bit is zero has its request blocked.
// RQ3 - First register bit 2 gates output compare channel 1.
// RQ4 - First register bit 1 gates input capture channel 1.
// RQ5 - First register bit 0 gates external interrupt 0 with the usual one-means-enabled coding.
// RQ6 - Second register bit 11 gates timer 4.
// RQ7 - Second register bit 2 gates the comparator.
// RQ8 - Second register bit 1 gates I2C port 1 master events.
// RQ9 - Second register bit 0 gates I2C port 1 slave events.
// RQ10 - All enable bits clear at reset, and second register bit 5 reads zero and ignores writes.
module ieb_enable_bank (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    // AXI4-Lite write address
    input  wire logic [3:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Source requests in, gated requests out
    input  wire ieb_pkg::ieb_req_t    src_req,
    output ieb_pkg::ieb_req_t         gated_req
);

    logic [15:0] irq_enable_first;
    logic [15:0] irq_enable_second;
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // Capture address and data separately so either may arrive first
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire hit_first  = (aw_addr == ieb_pkg::ADDR_ENABLE_FIRST);
    wire hit_second = (aw_addr == ieb_pkg::ADDR_ENABLE_SECOND);
    wire wr_ok = hit_first || hit_second;

    // Byte-lane merge; only the low two lanes carry register bits
    wire [15:0] lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [15:0] next_first = (irq_enable_first & ~lane_mask) | (w_data[15:0] & lane_mask);
    wire [15:0] next_second =
        ((irq_enable_second & ~lane_mask) | (w_data[15:0] & lane_mask))
        & ieb_pkg::MASK_ENABLE_SECOND; // [RQ10]

    // Read decode
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_first  = (s_axi_araddr == ieb_pkg::ADDR_ENABLE_FIRST);
    wire rd_second = (s_axi_araddr == ieb_pkg::ADDR_ENABLE_SECOND);
    wire [31:0] next_rdata = rd_first  ? {16'h0000, irq_enable_first} :
                             rd_second ? {16'h0000, irq_enable_second} : 32'h0000_0000;
    wire [1:0] next_rresp = (rd_first || rd_second) ? ieb_pkg::RESP_OKAY
                                                     : ieb_pkg::RESP_SLVERR;

    // Gating: each request passes only while its enable bit is one
    wire ieb_pkg::ieb_req_t next_gated;
    assign next_gated.first  = src_req.first & irq_enable_first; // [RQ1] [RQ2]
    assign next_gated.second = src_req.second & irq_enable_second; // [RQ1] [RQ2]

    // Named taps on the documented enable fields
    wire compare_one_irq_en       = irq_enable_first[ieb_pkg::POS_COMPARE_ONE]; // [RQ3]
    wire capture_one_irq_en       = irq_enable_first[ieb_pkg::POS_CAPTURE_ONE]; // [RQ4]
    wire ext_irq_zero_en          = irq_enable_first[ieb_pkg::POS_EXT_IRQ_ZERO]; // [RQ5]
    wire timer_four_irq_en        = irq_enable_second[ieb_pkg::POS_TIMER_FOUR]; // [RQ6]
    wire comparator_irq_en        = irq_enable_second[ieb_pkg::POS_COMPARATOR]; // [RQ7]
    wire i2c_master_event_irq_en  = irq_enable_second[ieb_pkg::POS_I2C_MASTER_EVENT]; // [RQ8]
    wire i2c_slave_event_irq_en   = irq_enable_second[ieb_pkg::POS_I2C_SLAVE_EVENT]; // [RQ9]

    // The field taps fix the documented layout of the low gated bits
    wire [2:0] first_low_gate  = {compare_one_irq_en, capture_one_irq_en, ext_irq_zero_en};
    wire [2:0] second_low_gate = {comparator_irq_en, i2c_master_event_irq_en,
                                  i2c_slave_event_irq_en};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gated_req <= '0;
        end else begin
            gated_req <= next_gated;
            gated_req.first[2:0] <= src_req.first[2:0] & first_low_gate; // [RQ3] [RQ4] [RQ5]
            gated_req.second[2:0] <= src_req.second[2:0] & second_low_gate; // [RQ7] [RQ8] [RQ9]
            gated_req.second[ieb_pkg::POS_TIMER_FOUR] <=
                src_req.second[ieb_pkg::POS_TIMER_FOUR] & timer_four_irq_en; // [RQ6]
        end
    end

    // Enable registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_enable_first  <= ieb_pkg::RESET_ENABLE_FIRST; // [RQ10]
            irq_enable_second <= ieb_pkg::RESET_ENABLE_SECOND; // [RQ10]
        end else if (do_write) begin
            if (hit_first) begin
                irq_enable_first <= next_first;
            end
            if (hit_second) begin
                irq_enable_second <= next_second;
            end
        end
    end

    // Write channels
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ieb_pkg::RESP_OKAY;
        end else begin
            // Ready is offered one cycle ahead so a held beat is never overwritten
            s_axi_awready <= !aw_held && !aw_take;
            s_axi_wready  <= !w_held && !w_take;
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? ieb_pkg::RESP_OKAY : ieb_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= ieb_pkg::RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// ==== verification/ieb_enable_bank_properties.sv ====
`timescale 1ns/1ns
module ieb_enable_bank_properties (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    // Bus handshakes
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // Requests
    input wire ieb_pkg::ieb_req_t src_req,
    input wire ieb_pkg::ieb_req_t gated_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_gate_block: assert property ((gated_req & ~$past(src_req)) == 32'h0000_0000)
        else $error("gated request without source");
    a_unimpl_quiet: assert property (gated_req.second[5] == 1'b0)
        else $error("unimplemented position passed a request");
    a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> gated_req == '0)
        else $error("gated requests not cleared by reset");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
endmodule
bind ieb_enable_bank ieb_enable_bank_properties u_props (.sys_clk, .sys_rst, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .src_req, .gated_req);

// ==== verification/ieb_enable_bank_tb.sv ====
`timescale 1ns/1ns
module ieb_enable_bank_tb;
    logic              sys_clk = 1'b0, sys_rst = 1'b1;
    logic [3:0]        s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0]       s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic              s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    ieb_pkg::ieb_req_t src_req = '0, gated_req;
    logic [15:0]       en1 = 16'h0000, en2 = 16'h0000;
    int                fail_count = 0, num_checks = 0;
    always #50 sys_clk = ~sys_clk;
    ieb_enable_bank dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_req, .gated_req);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Bready and rready stay high, so the ending edge is also the handshake
    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'hA5A5, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, {16'h0000, d});
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask
    function automatic logic [15:0] mrg(logic [15:0] o, logic [15:0] n, logic [3:0] s);
        return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
    endfunction
    task automatic set(input logic [15:0] e1, input logic [15:0] e2, input logic [3:0] s);
        wr(ieb_pkg::ADDR_ENABLE_FIRST, e1, s, ieb_pkg::RESP_OKAY);
        wr(ieb_pkg::ADDR_ENABLE_SECOND, e2, s, ieb_pkg::RESP_OKAY);
        en1 = mrg(en1, e1, s);
        en2 = mrg(en2, e2, s) & ieb_pkg::MASK_ENABLE_SECOND;
        rdc(ieb_pkg::ADDR_ENABLE_FIRST, en1, ieb_pkg::RESP_OKAY);
        rdc(ieb_pkg::ADDR_ENABLE_SECOND, en2, ieb_pkg::RESP_OKAY);
    endtask
    // Output lags source by one register stage
    task automatic gate(input logic [31:0] src);
        src_req <= src;
        repeat (2) @(posedge sys_clk);
        chk(gated_req, src & {en1, en2});
    endtask
    initial begin
        void'($urandom(65613));
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        gate(32'hFFFF_FFFF);
        rdc(4'h8, 16'h0000, ieb_pkg::RESP_SLVERR);
        wr(4'hC, 16'hFFFF, 4'hF, ieb_pkg::RESP_SLVERR);
        set(16'hFFFF, 16'hFFFF, 4'hF);
        gate(32'hFFFF_FFFF);
        set(16'h0004, 16'h0000, 4'h3);
        gate(32'hFFFF_FFFF);
        set(16'h0002, 16'h0000, 4'h3);
        gate(32'hFFFF_FFFF);
        set(16'h0001, 16'h0800, 4'h3);
        gate(32'h0000_FFFF);
        gate(32'hFFFF_0000);
        set(16'h0000, 16'h0006, 4'h3);
        gate(32'hFFFF_FFFB);
        gate(32'hFFFF_FFFD);
        set(16'h0000, 16'h0001, 4'h3);
        gate(32'hFFFF_FFFF);
        repeat (30) begin
            set(16'($urandom), 16'($urandom), 4'($urandom_range(1, 3)));
            gate($urandom);
        end
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        en1 = 16'h0000;
        en2 = 16'h0000;
        repeat (2) @(posedge sys_clk);
        rdc(ieb_pkg::ADDR_ENABLE_FIRST, en1, ieb_pkg::RESP_OKAY);
        gate(32'hFFFF_FFFF);
        complete_run;
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        fail_count++;
        complete_run;
    end
endmodule
